// *** design/sfcap_pkg.sv ***
// Package: constants for the serial flash command/address front end
package sfcap_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SEL_DELAY_US     = 1000;
  localparam int unsigned WRITE_DELAY_US   = 20000;
  localparam int unsigned SEL_DELAY_CYC    = SEL_DELAY_US * CLK_MHZ;
  localparam int unsigned WRITE_DELAY_CYC  = WRITE_DELAY_US * CLK_MHZ;

  localparam int unsigned PAGE_W   = 10;
  localparam int unsigned BYTE_W   = 9;
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned PAGE_LSB = 9;
  localparam int unsigned PAGE_HI7 = 3;
  localparam int unsigned PAGE_MSB = 9;
  localparam int unsigned CNT_W    = 6;
  localparam int unsigned OP_BITS  = 8;
  localparam int unsigned ADDR_BITS = 32;
  localparam int unsigned DUMMY1_BITS = 40;
  localparam int unsigned DUMMY4_BITS = 64;

  localparam logic [7:0] OP_RD_ARRAY  = 8'h03;
  localparam logic [7:0] OP_RD_FAST   = 8'h0B;
  localparam logic [7:0] OP_BLK_ERASE = 8'h50;
  localparam logic [7:0] OP_PG_XFER   = 8'h53;
  localparam logic [7:0] OP_PG_REWR   = 8'h58;
  localparam logic [7:0] OP_PG_CMP    = 8'h60;
  localparam logic [7:0] OP_SEC_RD    = 8'h77;
  localparam logic [7:0] OP_SECT_ERS  = 8'h7C;
  localparam logic [7:0] OP_PG_ERASE  = 8'h81;
  localparam logic [7:0] OP_PG_PROG   = 8'h82;
  localparam logic [7:0] OP_BUF_PROG  = 8'h83;
  localparam logic [7:0] OP_BUF_WR    = 8'h84;
  localparam logic [7:0] OP_BUF_PGNE  = 8'h88;
  localparam logic [7:0] OP_ID_RD     = 8'h9F;
  localparam logic [7:0] OP_DEEP_PD   = 8'hB9;
  localparam logic [7:0] OP_RESUME    = 8'hAB;
  localparam logic [7:0] OP_BUF_RD_LO = 8'hD1;
  localparam logic [7:0] OP_PG_RD     = 8'hD2;
  localparam logic [7:0] OP_BUF_RD_HI = 8'hD4;
  localparam logic [7:0] OP_STAT_RD   = 8'hD7;
  localparam logic [7:0] OP_CONT_RD   = 8'hE8;

  // Which address fields an opcode decodes
  typedef enum logic [2:0] {
    SFCAP_F_NONE, SFCAP_F_PAGE, SFCAP_F_PAGE7, SFCAP_F_PAGE1,
    SFCAP_F_BYTE, SFCAP_F_BOTH, SFCAP_F_DONTCARE
  } sfcap_field_t;

endpackage : sfcap_pkg

// *** design/sfcap_shift_if.sv ***
// Interface: sampled pin levels and shift events between front end and shifter
interface sfcap_shift_if;
  logic       clr;
  logic       shift;
  logic       bit_in;
  logic [5:0] count;
  logic [7:0] opcode;
  logic [23:0] addr;
  modport ctrl (output clr, output shift, output bit_in,
                input count, input opcode, input addr);
  modport shf  (input clr, input shift, input bit_in,
                output count, output opcode, output addr);
endinterface : sfcap_shift_if

// *** design/sfcap_shifter.sv ***
// Module: MSB-first shift register for opcode and address bytes
module sfcap_shifter
  import sfcap_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    sys_rst,
  sfcap_shift_if.shf   bus
);

  typedef struct packed {
    logic [5:0]  count;
    logic [7:0]  opcode;
    logic [23:0] addr;
  } sfcap_shf_state_t;

  sfcap_shf_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (bus.clr) begin
      s_d = '0;
    end else if (bus.shift) begin
      if (s_q.count < CNT_W'(OP_BITS)) begin
        s_d.opcode = {s_q.opcode[6:0], bus.bit_in};
      end else if (s_q.count < CNT_W'(ADDR_BITS)) begin
        s_d.addr = {s_q.addr[22:0], bus.bit_in};
      end
      if (s_q.count != '1) begin
        s_d.count = s_q.count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.count  = s_q.count;
  assign bus.opcode = s_q.opcode;
  assign bus.addr   = s_q.addr;

endmodule : sfcap_shifter

// *** design/sfcap_front.sv ***
// Module: command frame decoder and power-on gating for a serial flash
// Behaviour
// - Three address bytes follow the opcode: five reserved bits, 10 page bits, 9 byte bits; reserved bits are ignored.
// - Opcodes 53h 58h 60h 81h 83h 88h decode the page only, 50h the upper seven page bits, 7Ch the top page bit.
// - Opcodes 84h D1h D4h decode the byte field only, and 77h ignores every address bit.
// - One dummy byte follows the address for 0Bh and D4h, four for D2h and E8h; 9Fh B9h ABh D7h carry no address.
// - After reset the block assumes clock mode 3 and keeps its data output undriven.
// - An instruction is only interpreted after a falling edge of chip select.
// - Each falling edge of chip select seen in the idle state, outside power-on reset, samples the idle clock level to choose mode 0 or mode 3.
// - While power-on reset holds, nothing is done and no command is answered.
// - Once power-up completes the block sits in standby.
module sfcap_front
  import sfcap_pkg::*;
#(
  parameter int unsigned SEL_DELAY   = SEL_DELAY_CYC,
  parameter int unsigned WRITE_DELAY = WRITE_DELAY_CYC
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               por_active,
  input  wire logic               cs_n,
  input  wire logic               sck,
  input  wire logic               si,
  output logic                    so,
  output logic                    so_oe,
  output logic                    mode0,
  output logic                    standby,
  output logic                    read_ready,
  output logic                    write_ready,
  output logic                    cmd_valid,
  output logic [7:0]              cmd_opcode,
  output logic [PAGE_W-1:0]       cmd_page,
  output logic [BYTE_W-1:0]       cmd_byte,
  output logic [2:0]              cmd_field,
  output logic [2:0]              cmd_dummy
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] cs_sy, sck_sy, si_sy, por_sy;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cs_sy  <= 2'b11;
      sck_sy <= 2'b11;
      si_sy  <= 2'b00;
      por_sy <= 2'b11;
    end else begin
      cs_sy  <= {cs_sy[0], cs_n};
      sck_sy <= {sck_sy[0], sck};
      si_sy  <= {si_sy[0], si};
      por_sy <= {por_sy[0], por_active};
    end
  end

  wire cs_s  = cs_sy[1];
  wire sck_s = sck_sy[1];
  wire si_s  = si_sy[1];
  wire por_s = por_sy[1];

  // ------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SFCAP_ST_POR, SFCAP_ST_IDLE, SFCAP_ST_FRAME, SFCAP_ST_DONE}
    sfcap_state_t;

  typedef struct packed {
    sfcap_state_t       st;
    logic               cs_prev;
    logic               sck_prev;
    logic               mode0;
    logic [31:0]        tmr;
    logic               read_ready;
    logic               write_ready;
    logic               cmd_valid;
    logic [7:0]         op;
    logic [PAGE_W-1:0]  page;
    logic [BYTE_W-1:0]  byte_f;
    logic [2:0]         field;
    logic [2:0]         dummy;
  } sfcap_front_t;

  sfcap_front_t r_q, r_d;
  sfcap_shift_if sh ();

  sfcap_shifter u_shf (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .bus     (sh)
  );

  function automatic sfcap_field_t field_of(input logic [7:0] op);
    case (op)
      OP_PG_XFER, OP_PG_REWR, OP_PG_CMP, OP_PG_ERASE,
      OP_BUF_PROG, OP_BUF_PGNE:             field_of = SFCAP_F_PAGE;
      OP_BLK_ERASE:                         field_of = SFCAP_F_PAGE7;
      OP_SECT_ERS:                          field_of = SFCAP_F_PAGE1;
      OP_BUF_WR, OP_BUF_RD_LO, OP_BUF_RD_HI: field_of = SFCAP_F_BYTE;
      OP_SEC_RD:                            field_of = SFCAP_F_DONTCARE;
      OP_ID_RD, OP_DEEP_PD, OP_RESUME,
      OP_STAT_RD:                           field_of = SFCAP_F_NONE;
      default:                              field_of = SFCAP_F_BOTH;
    endcase
  endfunction : field_of

  function automatic logic [2:0] dummy_of(input logic [7:0] op);
    case (op)
      OP_RD_FAST, OP_BUF_RD_HI: dummy_of = 3'h1;
      OP_PG_RD, OP_CONT_RD:     dummy_of = 3'h4;
      default:                  dummy_of = 3'h0;
    endcase
  endfunction : dummy_of

  logic        cs_fall, sck_edge;
  logic [23:0] a;
  logic [5:0]  need;
  sfcap_field_t f;

  always_comb begin
    r_d        = r_q;
    r_d.cs_prev  = cs_s;
    r_d.sck_prev = sck_s;
    r_d.cmd_valid = 1'b0;
    cs_fall    = r_q.cs_prev & ~cs_s;
    // Sample on rising SCK in both modes
    sck_edge   = ~r_q.sck_prev & sck_s;
    a          = sh.addr;
    f          = field_of(sh.opcode);
    need       = (f == SFCAP_F_NONE) ? CNT_W'(OP_BITS) : CNT_W'(ADDR_BITS);
    sh.clr     = 1'b0;
    sh.shift   = 1'b0;
    sh.bit_in  = si_s;
    if (r_q.tmr != '1) begin
      r_d.tmr = r_q.tmr + 32'h0000_0001;
    end
    r_d.read_ready  = r_q.tmr >= SEL_DELAY;
    r_d.write_ready = r_q.tmr >= WRITE_DELAY;
    case (r_q.st)
      SFCAP_ST_POR: begin
        r_d.tmr = '0;
        r_d.read_ready  = 1'b0;
        r_d.write_ready = 1'b0;
        if (!por_s) begin
          r_d.st = SFCAP_ST_IDLE;
        end
      end
      SFCAP_ST_IDLE: begin
        if (cs_fall) begin
          r_d.mode0 = ~sck_s;
          sh.clr    = 1'b1;
          r_d.st    = SFCAP_ST_FRAME;
        end
      end
      SFCAP_ST_FRAME: begin
        if (cs_s) begin
          r_d.st = SFCAP_ST_IDLE;
        end else if (sh.count >= CNT_W'(OP_BITS) && sh.count == need) begin
          r_d.op     = sh.opcode;
          r_d.field  = f;
          r_d.dummy  = dummy_of(sh.opcode);
          r_d.page   = '0;
          r_d.byte_f = '0;
          case (f)
            SFCAP_F_PAGE:  r_d.page = a[PAGE_LSB +: PAGE_W];
            SFCAP_F_PAGE7: r_d.page = {a[PAGE_LSB+PAGE_HI7 +: PAGE_W-PAGE_HI7],
                                       PAGE_HI7'(0)};
            SFCAP_F_PAGE1: r_d.page = {a[PAGE_LSB+PAGE_MSB], (PAGE_W-1)'(0)};
            SFCAP_F_BYTE:  r_d.byte_f = a[BYTE_W-1:0];
            SFCAP_F_BOTH: begin
              r_d.page   = a[PAGE_LSB +: PAGE_W];
              r_d.byte_f = a[BYTE_W-1:0];
            end
            default: ;
          endcase
          r_d.cmd_valid = 1'b1;
          r_d.st = SFCAP_ST_DONE;
        end else if (sck_edge) begin
          sh.shift = 1'b1;
        end
      end
      SFCAP_ST_DONE: begin
        if (cs_s) begin
          r_d.st = SFCAP_ST_IDLE;
        end
      end
      default: r_d.st = SFCAP_ST_POR;
    endcase
    if (por_s) begin
      r_d.st        = SFCAP_ST_POR;
      r_d.cmd_valid = 1'b0;
      r_d.mode0     = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r_q          <= '0;
      r_q.st       <= SFCAP_ST_POR;
      r_q.cs_prev  <= 1'b1;
      r_q.sck_prev <= 1'b1;
      r_q.mode0    <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic so_q, so_oe_q, standby_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
      standby_q <= 1'b0;
    end else begin
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
      standby_q <= (r_q.st == SFCAP_ST_IDLE);
    end
  end

  assign so          = so_q;
  assign so_oe       = so_oe_q;
  assign standby     = standby_q;
  assign mode0       = r_q.mode0;
  assign read_ready  = r_q.read_ready;
  assign write_ready = r_q.write_ready;
  assign cmd_valid   = r_q.cmd_valid;
  assign cmd_opcode  = r_q.op;
  assign cmd_page    = r_q.page;
  assign cmd_byte    = r_q.byte_f;
  assign cmd_field   = r_q.field;
  assign cmd_dummy   = r_q.dummy;

endmodule : sfcap_front

// *** bench/sfcap_front_props.sv ***
// Checker: port-level properties of the command front end
module sfcap_front_props
  import sfcap_pkg::*;
#(
  parameter int unsigned SEL_DELAY   = 20,
  parameter int unsigned WRITE_DELAY = 50
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic por_active,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so_oe,
  input wire logic mode0,
  input wire logic standby,
  input wire logic read_ready,
  input wire logic write_ready,
  input wire logic cmd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] por_lo_q;

  // Cycles since power-on reset last held
  always_ff @(posedge mclk) begin
    if (sys_rst || por_active) por_lo_q <= '0;
    else if (por_lo_q != '1) por_lo_q <= por_lo_q + 1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence sel_low_s;
    standby && $fell(cs_n) && !sck;
  endsequence
  sequence sel_high_s;
    standby && $fell(cs_n) && sck;
  endsequence

  rst_state_a: assert property ($fell(sys_rst) |-> !mode0 && !so_oe && !standby)
    else $error("state after reset wrong");
  out_float_a: assert property (!so_oe)
    else $error("serial out driven");
  por_quiet_a: assert property (por_active [*5] |-> !cmd_valid && !standby && !read_ready && !write_ready)
    else $error("activity under power-on reset");
  sel_m0_a: assert property (sel_low_s |-> ##[1:5] mode0)
    else $error("mode 0 not picked");
  sel_m3_a: assert property (sel_high_s |-> ##[1:5] !mode0)
    else $error("mode 3 not picked");
  idle_quiet_a: assert property (cs_n [*8] |-> !cmd_valid)
    else $error("decode while deselected");
  valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("decode pulse too long");
  frame_busy_a: assert property (!cs_n [*6] |-> !standby)
    else $error("standby inside frame");
  rd_early_a: assert property ($rose(read_ready) |-> por_lo_q >= SEL_DELAY)
    else $error("read ready too early");
  wr_early_a: assert property ($rose(write_ready) |-> por_lo_q >= WRITE_DELAY)
    else $error("write ready too early");
endmodule : sfcap_front_props

bind sfcap_front sfcap_front_props #(.SEL_DELAY(SEL_DELAY), .WRITE_DELAY(WRITE_DELAY))
  i_sfcap_front_props (.mclk, .sys_rst, .por_active, .cs_n, .sck, .so_oe, .mode0,
                       .standby, .read_ready, .write_ready, .cmd_valid);

// *** bench/sfcap_host.sv ***
// Partner: host master that frames commands on the serial pins
module sfcap_host (
  input  logic mclk,
  output logic cs_n,
  output logic sck,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b1;
    si   = 1'b0;
  end

  // Send n bits MSB first; idle level sets the clock mode
  task automatic frame(input logic [31:0] w, input int n, input logic idle);
    // Quarter-ns offset keeps pin edges off the sampling clock edge
    #0.25;
    sck = idle;
    #64;
    cs_n = 1'b0;
    #32;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      si  = (i < 32) ? w[31-i] : $urandom();
      #32;
      sck = 1'b1;
      #32;
    end
    sck = idle;
    #32;
    cs_n = 1'b1;
    si   = ~si;
    #64;
    @(posedge mclk);
    #1;
  endtask : frame
endmodule : sfcap_host

// *** bench/sfcap_front_test.sv ***
// Testbench: command decode and power-up behaviour of the front end
module sfcap_front_test
  import sfcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        por_active = 1'b1;
  logic        cs_n, sck, si, so, so_oe, mode0, standby;
  logic        read_ready, write_ready, cmd_valid;
  logic [7:0]  cmd_opcode;
  logic [9:0]  cmd_page;
  logic [8:0]  cmd_byte;
  logic [2:0]  cmd_field, cmd_dummy;
  logic [32:0] got_q[$];
  int          bad_count = 0;
  int          compares = 0;
  logic [7:0]  ops[21] = '{8'h03, 8'h0B, 8'h50, 8'h53, 8'h58, 8'h60, 8'h77, 8'h7C, 8'h81,
                           8'h82, 8'h83, 8'h84, 8'h88, 8'h9F, 8'hB9, 8'hAB, 8'hD1, 8'hD2,
                           8'hD4, 8'hD7, 8'hE8};

  always #2.5 mclk = ~mclk;
  always @(negedge mclk) if (cmd_valid === 1'b1)
    got_q.push_back({cmd_opcode, cmd_page, cmd_byte, cmd_field, cmd_dummy});

  sfcap_host i_sfcap_host (.mclk, .cs_n, .sck, .si);
  sfcap_front #(.SEL_DELAY(20), .WRITE_DELAY(50)) i_sfcap_front (.mclk, .sys_rst,
    .por_active, .cs_n, .sck, .si, .so, .so_oe, .mode0, .standby, .read_ready,
    .write_ready, .cmd_valid, .cmd_opcode, .cmd_page, .cmd_byte, .cmd_field, .cmd_dummy);

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Expected decode: opcode, page, byte, field kind, dummy count
  function automatic logic [32:0] model(input logic [7:0] op, input logic [23:0] a);
    logic [9:0] pg;
    logic [8:0] by;
    logic [2:0] f;
    logic [2:0] d;
    pg = a[18:9];
    by = a[8:0];
    f  = SFCAP_F_BOTH;
    d  = 3'h0;
    case (op)
      8'h53, 8'h58, 8'h60, 8'h81, 8'h83, 8'h88: {by, f} = {9'h000, SFCAP_F_PAGE};
      8'h50: {pg, by, f} = {pg & 10'h3F8, 9'h000, SFCAP_F_PAGE7};
      8'h7C: {pg, by, f} = {pg & 10'h200, 9'h000, SFCAP_F_PAGE1};
      8'h84, 8'hD1: {pg, f} = {10'h000, SFCAP_F_BYTE};
      8'hD4: {pg, f, d} = {10'h000, SFCAP_F_BYTE, 3'h1};
      8'h0B: d = 3'h1;
      8'hD2, 8'hE8: d = 3'h4;
      8'h77: {pg, by, f} = {19'h0_0000, SFCAP_F_DONTCARE};
      8'h9F, 8'hB9, 8'hAB, 8'hD7: {pg, by, f} = {19'h0_0000, SFCAP_F_NONE};
      default: ;
    endcase
    return {op, pg, by, f, d};
  endfunction : model

  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic idle);
    logic [32:0] e;
    int          n;
    e = model(op, a);
    n = (e[5:3] == SFCAP_F_NONE) ? 8 : 32 + 8 * e[2:0];
    got_q.delete();
    i_sfcap_host.frame({op, a}, n, idle);
    chk("pulse count", 1, got_q.size());
    chk("command", e, got_q.size() ? got_q[0] : '0);
    chk("clock mode", !idle, mode0);
    chk("serial out", 0, {so, so_oe});
    chk("standby", 1, standby);
  endtask : run

  task automatic wait_flag(ref logic f, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (f !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(nm, 1, n >= lo && n <= hi);
    if (n == 200) complete_run();
  endtask : wait_flag

  initial begin
    int s;
    s = $urandom(32'h77a2_d3ff);
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    #1 chk("reset outputs", 0, {so_oe, mode0, standby});
    i_sfcap_host.frame({OP_STAT_RD, 24'h00_0000}, 8, 1'b1);
    chk("pulses under por", 0, got_q.size());
    chk("flags under por", 0, {standby, read_ready, write_ready});
    $display("test por done");
    @(posedge mclk);
    #1 por_active = 1'b0;
    wait_flag(read_ready, 20, 25, "read delay");
    chk("write early", 0, write_ready);
    wait_flag(write_ready, 25, 35, "write delay");
    chk("standby after power-up", 1, standby);
    $display("test power-up done");
    foreach (ops[i]) run(ops[i], 24'($urandom()), i[0]);
    $display("test opcodes done");
    got_q.delete();
    i_sfcap_host.frame({OP_PG_RD, 24'h01_2345}, 16, 1'b1);
    chk("aborted pulses", 0, got_q.size());
    run(OP_BUF_WR, 24'hFF_FFFF, 1'b0);
    $display("test abort done");
    por_active = 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk("outputs under por", 0, {standby, read_ready, write_ready, mode0});
    got_q.delete();
    i_sfcap_host.frame({OP_STAT_RD, 24'h00_0000}, 8, 1'b0);
    chk("pulses under por again", 0, got_q.size());
    por_active = 1'b0;
    wait_flag(read_ready, 20, 25, "read delay again");
    $display("test por again done");
    @(posedge mclk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    #1 chk("mode after reset", 0, {so_oe, mode0});
    wait_flag(standby, 1, 80, "standby again");
    wait_flag(write_ready, 45, 55, "write delay again");
    run(OP_SECT_ERS, 24'($urandom()), 1'b1);
    $display("test second reset done");
    complete_run();
  end
endmodule : sfcap_front_test
